// file: include/pflc_pkg.sv
// package: constants and types of the panel lock and current limit block
package pflc_pkg;
    // timing
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned CTRL_PERIOD_US  = 1000;
    localparam int unsigned CTRL_CYCLES     = CLK_HZ / 1_000_000 * CTRL_PERIOD_US;
    localparam int unsigned BLINK_HALF_MS   = 250;
    localparam int unsigned BLINK_CYCLES    = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam logic [3:0]  LOC_SHOW_HALVES = 4'h8;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_RATING   = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_VOUT     = 8'h14;
    localparam logic [7:0] ADDR_CMD      = 8'h18;

    // control register fields
    localparam int unsigned CTRL_DM_LSB    = 0;
    localparam int unsigned CTRL_KNOB_BIT  = 2;
    localparam int unsigned CTRL_CAR_LSB   = 4;
    localparam int unsigned CTRL_FAULT_LSB = 8;
    localparam int unsigned CMD_CLR_TRIP   = 0;

    // reset values and limits (rating in 0.1 A, voltage in V)
    localparam logic [1:0] DM_RST         = 2'h1;
    localparam logic [1:0] CAR_RST        = 2'h1;
    localparam logic [2:0] FAULT_RST      = 3'h0;
    localparam logic [7:0] RATING_RST     = 8'h64;
    localparam logic [7:0] RATING_MIN     = 8'h05;
    localparam logic [7:0] RATING_MAX     = 8'h78;
    localparam logic [7:0] RATING_MAX_EXT = 8'h8C;
    localparam logic [1:0] CAR_EXT        = 2'h2;
    localparam logic [7:0] TRIP_VOLT      = 8'h14;

    // driving methods
    localparam logic [1:0] DM_EXT       = 2'h0;
    localparam logic [1:0] DM_EXT_REV   = 2'h1;
    localparam logic [1:0] DM_PANEL     = 2'h2;
    localparam logic [1:0] DM_PANEL_SNS = 2'h3;

    // fault output functions
    localparam logic [2:0] FAULT_EM_CLOSE = 3'h0;
    localparam logic [2:0] FAULT_EM_OPEN  = 3'h1;
    localparam logic [2:0] FAULT_WARN     = 3'h2;
    localparam logic [2:0] FAULT_LIM_WARN = 3'h3;
    localparam logic [2:0] FAULT_RUNNING  = 3'h4;
    localparam logic [2:0] FAULT_READY    = 3'h5;

    // status and interrupt bits
    localparam int unsigned ST_LOCK    = 0;
    localparam int unsigned ST_KNOB    = 1;
    localparam int unsigned ST_DRIVING = 2;
    localparam int unsigned ST_LIMIT   = 3;
    localparam int unsigned ST_TRIP    = 4;
    localparam int unsigned IRQ_REFUSE = 0;
    localparam int unsigned IRQ_LIMIT  = 1;
    localparam int unsigned IRQ_TRIP   = 2;
    localparam int unsigned IRQ_W      = 3;

    // key pin vector positions
    localparam int unsigned KEY_STOP = 0;
    localparam int unsigned KEY_UP   = 1;
    localparam int unsigned KEY_DOWN = 2;
    localparam int unsigned KEY_RUN  = 3;
    localparam int unsigned PIN_X1   = 4;
    localparam int unsigned PIN_IN1  = 5;
    localparam int unsigned KEY_W    = 6;

    typedef enum logic [2:0] {
        DRV_STOP = 3'b001,
        DRV_RUN  = 3'b010,
        DRV_TRIP = 3'b100
    } pflc_drv_t;

    typedef enum logic [1:0] {
        DISP_VOLT  = 2'h0,
        DISP_OL    = 2'h1,
        DISP_LOC   = 2'h2,
        DISP_BLANK = 2'h3
    } pflc_disp_t;
endpackage : pflc_pkg

// file: logic/pflc_divider.sv
// divider: one-cycle enable pulse every DIV clocks
`timescale 1ns/1ns
`default_nettype none
module pflc_divider #(
    parameter int unsigned DIV = 2
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    output var  logic tick
);
    localparam int unsigned CW = $clog2(DIV);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_tick;

    // wrap at DIV-1 and pulse once
    always_comb begin
        if (cnt == CW'(DIV - 1)) begin
            next_cnt  = '0;
            next_tick = 1'b1;
        end else begin
            next_cnt  = cnt + 1'b1;
            next_tick = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule : pflc_divider
`default_nettype wire

// file: logic/pflc_limiter.sv
// limiter: output voltage ramp, current limiting and overload stop decision
`timescale 1ns/1ns
`default_nettype none
module pflc_limiter
    import pflc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic       enable,
    input  wire logic [7:0] fv_limit,
    input  wire logic [7:0] load_current,
    input  wire logic [7:0] rating,
    output var  logic [7:0] vout,
    output var  logic       limiting,
    output var  logic       trip
);
    logic [7:0] next_vout;
    logic       next_limiting;
    logic       next_trip;

    // one step per control update; steps of 1 V act as a soft ramp
    always_comb begin
        next_vout     = vout;
        next_limiting = limiting;
        next_trip     = 1'b0;
        if (!enable) begin
            next_vout     = 8'h00;
            next_limiting = 1'b0;
        end else if (tick) begin
            if (load_current > rating) begin
                next_limiting = 1'b1;
                if (vout <= TRIP_VOLT) begin
                    next_trip = 1'b1;
                end else begin
                    next_vout = vout - 8'h01;
                end
            end else if (vout < fv_limit) begin
                next_vout = vout + 8'h01;
            end else begin
                next_limiting = 1'b0;
            end
            // the curve bound always wins over the ramp
            if (next_vout > fv_limit) begin
                next_vout = fv_limit;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vout     <= 8'h00;
            limiting <= 1'b0;
            trip     <= 1'b0;
        end else begin
            vout     <= next_vout;
            limiting <= next_limiting;
            trip     <= next_trip;
        end
    end
endmodule : pflc_limiter
`default_nettype wire

// file: logic/pflc_top.sv
// top: panel lock, settings registers, drive control and overload handling
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module pflc_top #(
    parameter int unsigned CTRL_DIV  = pflc_pkg::CTRL_CYCLES,
    parameter int unsigned BLINK_DIV = pflc_pkg::BLINK_CYCLES
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 hsel,
    input  wire logic [7:0]           haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output var  logic [31:0]          hrdata,
    output var  logic                 hreadyout,
    output var  logic                 hresp,
    input  wire logic                 key_stop,
    input  wire logic                 key_up,
    input  wire logic                 key_down,
    input  wire logic                 key_run,
    input  wire logic                 ext_run_x1,
    input  wire logic                 sensor_in1,
    input  wire logic [7:0]           load_current,
    input  wire logic [7:0]           fv_limit,
    output var  logic [7:0]           vout,
    output var  logic                 driving,
    output var  logic                 fault_contact_output,
    output var  pflc_pkg::pflc_disp_t disp_code,
    output var  logic                 irq
);
    import pflc_pkg::*;

    logic [KEY_W-1:0] pins;
    logic [KEY_W-1:0] sync1;
    logic [KEY_W-1:0] sync2;
    logic [KEY_W-1:0] sync3;
    logic [KEY_W-1:0] rise;
    logic             ctrl_tick;
    logic             blink_tick;
    logic             limiting;
    logic             trip;

    assign pins = {sensor_in1, ext_run_x1, key_run, key_down, key_up, key_stop};
    assign rise = sync2 & ~sync3;

    // pins are asynchronous: two flops, then a third for edge detection
    generate
        for (genvar i = 0; i < KEY_W; i++) begin : g_sync
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    sync1[i] <= 1'b0;
                    sync2[i] <= 1'b0;
                    sync3[i] <= 1'b0;
                end else begin
                    sync1[i] <= pins[i];
                    sync2[i] <= sync1[i];
                    sync3[i] <= sync2[i];
                end
            end
        end
    endgenerate

    pflc_divider #(.DIV(CTRL_DIV)) u_ctrl_div (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tick    (ctrl_tick)
    );

    pflc_divider #(.DIV(BLINK_DIV)) u_blink_div (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tick    (blink_tick)
    );

    // ---------------- bus slave ----------------
    logic [7:0]  addr_q;
    logic        wr_q;
    logic        rd_q;
    logic [7:0]  next_addr_q;
    logic        next_wr_q;
    logic        next_rd_q;
    logic        next_hreadyout;
    logic [31:0] next_hrdata;
    logic [31:0] rd_word;
    logic        accept;

    // register state visible to reads
    logic             lock;
    logic             knob;
    logic [1:0]       dm;
    logic [1:0]       car;
    logic [2:0]       fault;
    logic [7:0]       rating;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    pflc_drv_t        state;

    assign accept = hsel & htrans[1] & hready;
    assign hresp  = 1'b0;

    // read mux; all settings stay readable whatever the lock
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (addr_q)
            ADDR_CTRL: begin
                rd_word[CTRL_DM_LSB +: 2]    = dm;
                rd_word[CTRL_KNOB_BIT]       = knob;
                rd_word[CTRL_CAR_LSB +: 2]   = car;
                rd_word[CTRL_FAULT_LSB +: 3] = fault;
            end
            ADDR_RATING:   rd_word[7:0] = rating;
            ADDR_STATUS: begin
                rd_word[ST_LOCK]    = lock;
                rd_word[ST_KNOB]    = knob;
                rd_word[ST_DRIVING] = (state == DRV_RUN);
                rd_word[ST_LIMIT]   = limiting;
                rd_word[ST_TRIP]    = (state == DRV_TRIP);
            end
            ADDR_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat;
            ADDR_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask;
            ADDR_VOUT:     rd_word[7:0] = vout;
            default:       rd_word = 32'h0000_0000;
        endcase
    end

    // reads take one wait state so data reflect writes just before them
    always_comb begin
        next_addr_q    = addr_q;
        next_wr_q      = 1'b0;
        next_rd_q      = 1'b0;
        next_hreadyout = 1'b1;
        next_hrdata    = hrdata;
        if (rd_q) begin
            next_hrdata = rd_word;
        end
        if (accept) begin
            next_addr_q    = haddr;
            next_wr_q      = hwrite;
            next_rd_q      = ~hwrite;
            next_hreadyout = hwrite;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            addr_q    <= 8'h00;
            wr_q      <= 1'b0;
            rd_q      <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
        end else begin
            addr_q    <= next_addr_q;
            wr_q      <= next_wr_q;
            rd_q      <= next_rd_q;
            hreadyout <= next_hreadyout;
            hrdata    <= next_hrdata;
        end
    end

    // ---------------- settings ----------------
    logic       next_lock;
    logic       next_knob;
    logic [1:0] next_dm;
    logic [1:0] next_car;
    logic [2:0] next_fault;
    logic [7:0] next_rating;
    logic       refused;
    logic       next_refused;
    logic [3:0] loc_timer;
    logic [3:0] next_loc_timer;
    logic       stopped;
    logic       wr_ctrl;
    logic       wr_rating;

    assign stopped   = (state != DRV_RUN);
    assign wr_ctrl   = wr_q & (addr_q == ADDR_CTRL);
    assign wr_rating = wr_q & (addr_q == ADDR_RATING);

    // rating range depends on carrier selection
    function automatic logic rating_ok(input logic [7:0] v,
                                       input logic [1:0] c);
        logic [7:0] top;
        top = (c == CAR_EXT) ? RATING_MAX_EXT : RATING_MAX;
        return (v >= RATING_MIN) && (v <= top);
    endfunction : rating_ok

    always_comb begin
        next_lock      = lock;
        next_knob      = knob;
        next_dm        = dm;
        next_car       = car;
        next_fault     = fault;
        next_rating    = rating;
        next_refused   = 1'b0;
        next_loc_timer = loc_timer;
        if (blink_tick && loc_timer != 4'h0) begin
            next_loc_timer = loc_timer - 4'h1;
        end
        // the key chord is the only path to the lock bit
        if (stopped && sync2[KEY_STOP]) begin
            if (rise[KEY_UP]) begin
                next_lock = 1'b1;
            end else if (rise[KEY_DOWN]) begin
                next_lock = 1'b0;
                if (lock) begin
                    next_knob = 1'b0;
                end
            end
        end
        if (wr_ctrl) begin
            next_knob = hwdata[CTRL_KNOB_BIT];
            if (lock || !stopped) begin
                if (hwdata[CTRL_DM_LSB +: 2] != dm ||
                    hwdata[CTRL_CAR_LSB +: 2] != car ||
                    hwdata[CTRL_FAULT_LSB +: 3] != fault) begin
                    next_refused = 1'b1;
                end
            end else begin
                next_dm    = hwdata[CTRL_DM_LSB +: 2];
                next_car   = hwdata[CTRL_CAR_LSB +: 2];
                next_fault = hwdata[CTRL_FAULT_LSB +: 3];
            end
        end
        if (wr_rating) begin
            if (lock || !stopped || !rating_ok(hwdata[7:0], car)) begin
                next_refused = 1'b1;
            end else begin
                next_rating = hwdata[7:0];
            end
        end
        if (next_refused && lock) begin
            next_loc_timer = LOC_SHOW_HALVES;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lock      <= 1'b0;
            knob      <= 1'b0;
            dm        <= DM_RST;
            car       <= CAR_RST;
            fault     <= FAULT_RST;
            rating    <= RATING_RST;
            refused   <= 1'b0;
            loc_timer <= 4'h0;
        end else begin
            lock      <= next_lock;
            knob      <= next_knob;
            dm        <= next_dm;
            car       <= next_car;
            fault     <= next_fault;
            rating    <= next_rating;
            refused   <= next_refused;
            loc_timer <= next_loc_timer;
        end
    end

    // ---------------- drive control ----------------
    pflc_drv_t next_state;
    logic      panel_run;
    logic      next_panel_run;
    logic      want;

    // run request per driving method; x1 high means terminal open
    always_comb begin
        unique case (dm)
            DM_EXT:     want = sync2[PIN_X1] & sync2[PIN_IN1];
            DM_EXT_REV: want = ~sync2[PIN_X1] & sync2[PIN_IN1];
            DM_PANEL:   want = panel_run;
            default:    want = panel_run & sync2[PIN_IN1];
        endcase
    end

    // panel keys act regardless of the lock; stop beats run
    always_comb begin
        next_state     = state;
        next_panel_run = panel_run;
        if (rise[KEY_RUN]) begin
            next_panel_run = 1'b1;
        end
        if (rise[KEY_STOP]) begin
            next_panel_run = 1'b0;
        end
        unique case (state)
            DRV_STOP: if (want) next_state = DRV_RUN;
            DRV_RUN: begin
                if (trip) begin
                    next_state     = DRV_TRIP;
                    next_panel_run = 1'b0;
                end else if (!want) begin
                    next_state = DRV_STOP;
                end
            end
            DRV_TRIP: begin
                next_panel_run = 1'b0;
                if (wr_q && addr_q == ADDR_CMD && hwdata[CMD_CLR_TRIP]) begin
                    next_state = DRV_STOP;
                end
            end
            default: next_state = DRV_STOP;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state     <= DRV_STOP;
            panel_run <= 1'b0;
        end else begin
            state     <= next_state;
            panel_run <= next_panel_run;
        end
    end

    pflc_limiter u_limiter (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .tick         (ctrl_tick),
        .enable       (state == DRV_RUN),
        .fv_limit     (fv_limit),
        .load_current (load_current),
        .rating       (rating),
        .vout         (vout),
        .limiting     (limiting),
        .trip         (trip)
    );

    // ---------------- interrupts ----------------
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] next_irq_mask;
    logic [IRQ_W-1:0] events;
    logic             lim_prev;
    logic             next_irq;

    // write one to clear; a same-cycle event keeps its bit set
    always_comb begin
        events             = '0;
        events[IRQ_REFUSE] = refused;
        events[IRQ_LIMIT]  = limiting & ~lim_prev;
        events[IRQ_TRIP]   = trip & (state == DRV_RUN);
        next_irq_stat      = irq_stat;
        next_irq_mask      = irq_mask;
        if (wr_q && addr_q == ADDR_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~hwdata[IRQ_W-1:0];
        end
        if (wr_q && addr_q == ADDR_IRQ_MASK) begin
            next_irq_mask = hwdata[IRQ_W-1:0];
        end
        next_irq_stat = next_irq_stat | events;
        next_irq      = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_stat <= '0;
            irq_mask <= '0;
            lim_prev <= 1'b0;
            irq      <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            lim_prev <= limiting;
            irq      <= next_irq;
        end
    end

    // ---------------- display and fault contact ----------------
    logic       blink;
    logic       next_blink;
    pflc_disp_t next_disp;
    logic       next_fault_out;
    logic       next_driving;

    // priority: overload stop, refused edit, limiting, voltage
    always_comb begin
        next_blink   = blink_tick ? ~blink : blink;
        next_driving = (next_state == DRV_RUN);
        if (state == DRV_TRIP) begin
            next_disp = DISP_OL;
        end else if (loc_timer != 4'h0) begin
            next_disp = blink ? DISP_LOC : DISP_BLANK;
        end else if (limiting) begin
            next_disp = blink ? DISP_OL : DISP_VOLT;
        end else begin
            next_disp = DISP_VOLT;
        end
        unique case (fault)
            FAULT_EM_CLOSE: next_fault_out = (state == DRV_TRIP);
            FAULT_EM_OPEN:  next_fault_out = (state != DRV_TRIP);
            FAULT_WARN:     next_fault_out = limiting;
            FAULT_LIM_WARN: next_fault_out = limiting;
            FAULT_RUNNING:  next_fault_out = (state == DRV_RUN);
            FAULT_READY:    next_fault_out = (state != DRV_TRIP);
            default:        next_fault_out = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            blink                <= 1'b0;
            disp_code            <= DISP_VOLT;
            fault_contact_output <= 1'b0;
            driving              <= 1'b0;
        end else begin
            blink                <= next_blink;
            disp_code            <= next_disp;
            fault_contact_output <= next_fault_out;
            driving              <= next_driving;
        end
    end
endmodule : pflc_top
`default_nettype wire

// file: dv/pflc_load_model.sv
// load model: current drawn by the vibratory load at a given voltage
`timescale 1ns/1ns
`default_nettype none
module pflc_load_model (
    input  wire logic       heavy,
    input  wire logic [7:0] vout,
    output var  logic [7:0] load_current
);
    // 0.1 A per volt; a jammed load draws 20.0 A whatever the voltage
    assign load_current = heavy ? 8'hC8 : vout;
endmodule : pflc_load_model
`default_nettype wire

// file: dv/pflc_checker.sv
// checker: bus handshake and output voltage relations at the top ports
`timescale 1ns/1ns
`default_nettype none
module pflc_checker (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [7:0]  fv_limit,
    input wire logic [7:0]  vout,
    input wire logic        driving
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // a transfer is taken only while hready is high
    wire logic take = hsel && htrans[1] && hready;
    // reads cost one wait state, writes none; data held between reads
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved");
    a_resp_okay: assert property (hresp == 1'h0)
        else $error("error response");
    // voltage starts from zero, climbs one step at most, stays on the curve
    a_stop_vout_zero: assert property (!driving [*3] |-> vout == 8'h00)
        else $error("voltage while stopped");
    a_rise_from_zero: assert property ($rose(driving) |-> vout == 8'h00)
        else $error("drive began above zero");
    a_vout_curve: assert property ($stable(fv_limit) [*2] |-> vout <= fv_limit)
        else $error("voltage above curve");
    a_vout_step: assert property (driving && $past(driving) |-> vout <= $past(vout) + 1)
        else $error("voltage jumped");
endmodule : pflc_checker
bind pflc_top pflc_checker i_pflc_checker (.sys_clk, .rst, .hsel, .htrans,
    .hwrite, .hready, .hrdata, .hreadyout, .hresp, .fv_limit, .vout,
    .driving);
`default_nettype wire

// file: dv/pflc_tb_top.sv
// testbench: settings bus, keypad lock and overload stop scenarios
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED %0t got %0h want %0h", $time, a, b); end end
module pflc_tb_top;
    import pflc_pkg::*;
    logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, heavy = 0, in1 = 1;
    logic [1:0] htrans = 0;
    logic [3:0] keys = 0; // run, down, up, stop
    logic [7:0] haddr = 0, v, want = 8'h64, fv = 8'h50;
    logic [7:0] edge_v [6] = '{8'h04, 8'h05, 8'h78, 8'h79, 8'h8C, 8'h8D};
    logic [31:0] hwdata = 0, rd;
    wire logic [31:0] hrdata;
    wire logic [7:0] vout, cur;
    wire logic hreadyout, hresp, driving, fco, irq;
    pflc_disp_t disp;
    int bad_count = 0, compares = 0, cyc = 0;
    // short dividers keep ramps and blink phases to a few hundred cycles
    pflc_top #(.CTRL_DIV(8), .BLINK_DIV(16)) i_pflc_top (.sys_clk, .rst,
        .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .key_stop(keys[0]), .key_up(keys[1]), .key_down(keys[2]),
        .key_run(keys[3]), .ext_run_x1(1'h1), .sensor_in1(in1),
        .load_current(cur), .fv_limit(fv), .vout, .driving,
        .fault_contact_output(fco), .disp_code(disp), .irq);
    pflc_load_model i_pflc_load_model (.heavy, .vout, .load_current(cur));
    always #10 sys_clk = ~sys_clk;
    // hang guard, far above the fewer than two thousand cycles needed
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin bad_count++; give_verdict(); end
    end
    // single word transfer; read data taken at the edge ending the wait
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge sys_clk); while (!hreadyout);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (!hreadyout);
        rd = hrdata;
    endtask : bus
    // stop goes down first so it is already held when the other key rises
    task automatic press(input logic [3:0] k);
        keys <= k & 4'h1;
        repeat (5) @(posedge sys_clk);
        keys <= k;
        repeat (5) @(posedge sys_clk);
        keys <= 4'h0;
        repeat (5) @(posedge sys_clk);
    endtask : press
    // accepted rating span widens only for carrier select 2
    function automatic logic ok(input logic [7:0] r, input logic [1:0] c);
        return r >= RATING_MIN &&
               r <= (c == CAR_EXT ? RATING_MAX_EXT : RATING_MAX);
    endfunction : ok
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    initial begin
        void'($urandom(87743));
        repeat (3) @(posedge sys_clk);
        rst <= 1'h0;
        @(posedge sys_clk);
        bus(1'h0, ADDR_RATING, 32'h0);
        `CHK(rd, 32'h64);
        bus(1'h0, 8'h40, 32'h0);
        `CHK(rd, 32'h0);
        // edge and random ratings, normal then extended carrier range
        for (int c = 1; c < 3; c++) begin
            bus(1'h1, ADDR_CTRL, 32'(c * 16 + 2));
            for (int i = 0; i < 9; i++) begin
                v = (i < 6) ? edge_v[i] : 8'($urandom);
                bus(1'h1, ADDR_RATING, {24'h0, v});
                if (ok(v, 2'(c))) want = v;
                bus(1'h0, ADDR_RATING, 32'h0);
                `CHK(rd[7:0], want);
            end
        end
        // knob lock on, sane rating, then lock and try an edit
        bus(1'h1, ADDR_CTRL, 32'h6);
        bus(1'h1, ADDR_RATING, 32'h64);
        bus(1'h1, ADDR_IRQ_STAT, 32'h7);
        bus(1'h1, ADDR_IRQ_MASK, 32'h1);
        press(4'h3);
        bus(1'h1, ADDR_RATING, 32'h50);
        bus(1'h0, ADDR_RATING, 32'h0);
        `CHK(rd, 32'h64);
        `CHK(disp[1], 1'h1);
        bus(1'h0, ADDR_STATUS, 32'h0);
        `CHK(rd[1:0], 2'h3);
        `CHK(irq, 1'h1);
        bus(1'h1, ADDR_IRQ_MASK, 32'h0);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'h0);
        bus(1'h1, ADDR_IRQ_STAT, 32'h1);
        bus(1'h0, ADDR_IRQ_STAT, 32'h0);
        `CHK(rd[0], 1'h0);
        press(4'h5);
        bus(1'h0, ADDR_STATUS, 32'h0);
        `CHK(rd[1:0], 2'h0);
        // warning contact first, then emergency contact on a jammed start
        for (int f = 2; f >= 0; f -= 2) begin
            bus(1'h1, ADDR_CTRL, 32'(f * 256 + 2));
            press(4'h3);
            press(4'h8);
            if (f == 2) begin
                `CHK(driving, 1'h1);
                for (int n = 0; n < 2000 && vout !== 8'h50; n++) @(posedge sys_clk);
                `CHK(vout, 8'h50);
                heavy <= 1'h1;
                repeat (40) @(posedge sys_clk);
                `CHK(fco, 1'h1);
                `CHK(driving, 1'h1);
                for (int n = 0; n < 40 && disp !== DISP_OL; n++)
                    @(posedge sys_clk);
                `CHK(disp, DISP_OL);
            end
            for (int n = 0; n < 2000 && driving; n++) @(posedge sys_clk);
            repeat (2) @(posedge sys_clk);
            `CHK(disp, DISP_OL);
            if (f == 0) `CHK(fco, 1'h1);
            bus(1'h0, ADDR_STATUS, 32'h0);
            `CHK(rd[4], 1'h1);
            bus(1'h1, ADDR_CMD, 32'h1);
            press(4'h5);
        end
        // sensor-gated panel method, then a lower curve bound
        heavy <= 1'h0;
        in1 <= 1'h0;
        fv <= 8'h10;
        bus(1'h1, ADDR_CTRL, 32'h3);
        press(4'h8);
        `CHK(driving, 1'h0);
        in1 <= 1'h1;
        repeat (200) @(posedge sys_clk);
        `CHK(driving, 1'h1);
        `CHK(vout, 8'h10);
        give_verdict();
    end
endmodule : pflc_tb_top
`default_nettype wire
